/* common/asu_defines.svh */
// Register offsets, field positions and reset values of the serial unit.
// Assumes inclusion by bare name from design files.
`ifndef ASU_DEFINES_SVH
`define ASU_DEFINES_SVH
`define ASU_OFF_MODE      12'h000
`define ASU_OFF_RXERR     12'h004
`define ASU_OFF_TXSTAT    12'h008
`define ASU_OFF_CLKSEL    12'h00C
`define ASU_OFF_BAUD      12'h010
`define ASU_OFF_LINCTL    12'h014
`define ASU_OFF_TXBUF     12'h018
`define ASU_OFF_RXBUF     12'h01C
`define ASU_BIT_POWER     7
`define ASU_BIT_TXEN      6
`define ASU_BIT_RXEN      5
`define ASU_BIT_PS_HI     4
`define ASU_BIT_PS_LO     3
`define ASU_BIT_CLEN      2
`define ASU_BIT_STOP2     1
`define ASU_BIT_ERRMODE   0
`define ASU_BIT_BRK_TX    6
`define ASU_BIT_BRK_RX    5
`define ASU_BIT_BRK_FLAG  7
`define ASU_MODE_RST      8'h01
`define ASU_BAUD_RST      8'hFF
`define ASU_CLKSEL_RST    4'h0
`define ASU_BRK_TX_BITS   5'h0D
`define ASU_BRK_RX_BITS   5'h0B
`define ASU_GAP_CLKS      2'h2
`endif

/* common/asu_pkg.sv */
// Types shared by the serial unit files.
// Assumes asu_defines.svh is compiled alongside.
`default_nettype none
package asu_pkg;
  typedef enum logic [2:0] {
    ASU_IDLE  = 3'h0,
    ASU_START = 3'h1,
    ASU_DATA  = 3'h3,
    ASU_PAR   = 3'h2,
    ASU_STOP  = 3'h6,
    ASU_GAP   = 3'h7
  } asu_state_e;
  typedef struct packed {
    logic       parity_error_flag;
    logic       framing_error;
    logic       overrun_error;
  } asu_rxerr_s;
  typedef struct packed {
    logic       tx_buffer_full_flag;
    logic       tx_shift_busy_flag;
  } asu_txstat_s;
endpackage
`default_nettype wire

/* core/asu_baud.sv */
// Baud tick generator: prescaler then 8-bit counter, output halved.
// Assumes prescaler select and divisor are stable while counting.
`default_nettype none
`include "asu_defines.svh"
module asu_baud #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             run,
  input  wire logic [3:0]       prescale_sel,
  input  wire logic [DIV_W-1:0] divisor,
  // Tick out
  output logic                  baud_tick
);
  logic [15:0]      pre_cnt_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic             half_reg;
  logic             pre_tick;

  assign pre_tick = (pre_cnt_reg == ((16'h0001 << prescale_sel) - 16'h0001));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= 16'h0000;
    end else if (!run || pre_tick) begin
      pre_cnt_reg <= 16'h0000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 16'h0001;
    end
  end

  // Counter output halved to form the bit clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= '0;
      half_reg    <= 1'b0;
      baud_tick   <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (!run) begin
        div_cnt_reg <= '0;
        half_reg    <= 1'b0;
      end else if (pre_tick) begin
        if (div_cnt_reg >= divisor - DIV_W'(1)) begin
          div_cnt_reg <= '0;
          half_reg    <= ~half_reg;
          baud_tick   <= half_reg;
        end else begin
          div_cnt_reg <= div_cnt_reg + DIV_W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* core/asu_top.sv */
// Async serial unit with LIN break support, APB register slave.
// Assumes one clock pclk; serial_rx_line is asynchronous and synchronised.
//
// Implementation choices: register access over APB and the placing of the registers.
`default_nettype none
`include "asu_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Power and receive enable with line low starts reception immediately.
// - Receiver always uses one stop bit; stop count affects transmit only.
// - Parity error flag follows the selected parity mode.
// - Framing check looks only at the first stop bit position.
// - After overrun the next received character is discarded.
// - Reading receive error status inserts one bus wait cycle.
// - Baud clock is the 8-bit counter output divided by two.
// - Power, transmit and receive enable are mode bits 7, 6, 5.
// - Break transmit trigger self-clears at completion; rewrite restarts it.
// - Break flag keeps its value after a break reception error; only a good break sets it.
// - Break receive trigger reads zero and clears after a good break.
// - Continuous transmission waits two clocks into the stop bit before the next start may begin.
module asu_top #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial lines
  input  wire logic        serial_rx_line,
  output logic             serial_tx_line,
  // Events
  output logic             tx_done_pulse,
  output logic             rx_done_pulse
);
  logic [7:0]       operation_mode_reg;
  logic [3:0]       clock_select_reg;
  logic [DIV_W-1:0] baud_control_reg;
  logic             break_tx_trigger_reg;
  logic             break_rx_trigger_reg;
  logic             break_rx_flag_reg;
  logic [7:0]       transmit_buffer;
  logic [7:0]       receive_buffer;
  logic             buf_full_reg;
  asu_pkg::asu_rxerr_s rx_err_reg;
  logic             wait_done_reg;
  logic             rx_s1_reg;
  logic             rx_s2_reg;
  logic             baud_tick;
  logic             unit_power_enable;
  logic             transmit_enable;
  logic             receive_enable;
  logic             apb_setup;
  logic             apb_wr;
  logic             apb_rd;
  logic             tx_busy_reg;
  logic             rx_tick;
  logic             brk_rx_ok;
  logic [23:0]      rx_tmr_reg;

  assign unit_power_enable = operation_mode_reg[`ASU_BIT_POWER];
  assign transmit_enable   = unit_power_enable && operation_mode_reg[`ASU_BIT_TXEN];
  assign receive_enable    = unit_power_enable && operation_mode_reg[`ASU_BIT_RXEN];
  assign apb_setup = psel && !penable;

  function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] sel,
                                      input logic len8);
    logic p;
    p = ^(len8 ? d : {1'b0, d[6:0]});
    case (sel)
      2'h1:    parity_bit = 1'b0;
      2'h2:    parity_bit = p;
      2'h3:    parity_bit = ~p;
      default: parity_bit = 1'b0;
    endcase
  endfunction

  // Pclk cycles in one bit time
  function automatic logic [23:0] bit_clks(input logic [3:0] sel, input logic [DIV_W-1:0] div);
    bit_clks = (24'(div) << sel) << 1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock
  asu_baud #(.DIV_W(DIV_W)) u_baud (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (unit_power_enable),
    .prescale_sel (clock_select_reg),
    .divisor      (baud_control_reg),
    .baud_tick    (baud_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake; error status read waits one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_done_reg <= 1'b0;
    end else begin
      wait_done_reg <= psel && penable && !pready && (paddr == `ASU_OFF_RXERR);
    end
  end

  always_comb begin
    pready = 1'b1;
    if (psel && penable && !pwrite && (paddr == `ASU_OFF_RXERR) && !wait_done_reg) begin
      pready = 1'b0;
    end
  end

  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd = psel && penable && pready && !pwrite;
  assign pslverr = 1'b0;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `ASU_OFF_MODE:   prdata = {24'h000000, operation_mode_reg};
      `ASU_OFF_RXERR:  prdata = {29'h00000000, rx_err_reg};
      `ASU_OFF_TXSTAT: prdata = {30'h00000000, buf_full_reg, tx_busy_reg};
      `ASU_OFF_CLKSEL: prdata = {28'h0000000, clock_select_reg};
      `ASU_OFF_BAUD:   prdata = {{(32-DIV_W){1'b0}}, baud_control_reg};
      `ASU_OFF_LINCTL: prdata = {24'h000000, break_rx_flag_reg, break_tx_trigger_reg,
                                 6'h00};
      `ASU_OFF_RXBUF:  prdata = {24'h000000, receive_buffer};
      default:         prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operation_mode_reg <= `ASU_MODE_RST;
      clock_select_reg   <= `ASU_CLKSEL_RST;
      baud_control_reg   <= DIV_W'(`ASU_BAUD_RST);
    end else if (apb_wr) begin
      case (paddr)
        `ASU_OFF_MODE:   operation_mode_reg <= pwdata[7:0];
        `ASU_OFF_CLKSEL: clock_select_reg   <= pwdata[3:0];
        `ASU_OFF_BAUD:   baud_control_reg   <= pwdata[DIV_W-1:0];
        default:         ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive line synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= serial_rx_line;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  asu_pkg::asu_state_e tx_state_reg;
  logic [8:0]  tx_shift_reg;
  logic [3:0]  tx_cnt_reg;
  logic [1:0]  tx_gap_reg;
  logic        tx_brk_reg;
  logic        tx_go;
  logic [3:0]  tx_nbits;

  assign tx_nbits = operation_mode_reg[`ASU_BIT_CLEN] ? 4'h8 : 4'h7;
  assign tx_go = transmit_enable && baud_tick && (buf_full_reg || break_tx_trigger_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_buffer <= 8'h00;
      buf_full_reg    <= 1'b0;
    end else begin
      if (tx_state_reg == asu_pkg::ASU_IDLE && tx_go && !break_tx_trigger_reg) begin
        buf_full_reg <= 1'b0;
      end
      if (!transmit_enable) begin
        buf_full_reg <= 1'b0;
      end else if (apb_wr && paddr == `ASU_OFF_TXBUF) begin
        transmit_buffer <= pwdata[7:0];
        buf_full_reg    <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_tx_trigger_reg <= 1'b0;
    end else if (apb_wr && paddr == `ASU_OFF_LINCTL && pwdata[`ASU_BIT_BRK_TX]) begin
      break_tx_trigger_reg <= 1'b1;
    end else if (tx_done_pulse && tx_brk_reg) begin
      break_tx_trigger_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg   <= asu_pkg::ASU_IDLE;
      tx_shift_reg   <= 9'h1FF;
      tx_cnt_reg     <= 4'h0;
      tx_gap_reg     <= 2'h0;
      tx_busy_reg    <= 1'b0;
      tx_brk_reg     <= 1'b0;
      serial_tx_line <= 1'b1;
      tx_done_pulse  <= 1'b0;
    end else begin
      tx_done_pulse <= 1'b0;
      if (!transmit_enable) begin
        tx_state_reg   <= asu_pkg::ASU_IDLE;
        tx_busy_reg    <= 1'b0;
        serial_tx_line <= 1'b1;
      end else begin
        case (tx_state_reg)
          asu_pkg::ASU_IDLE: if (tx_go) begin
            tx_busy_reg    <= 1'b1;
            serial_tx_line <= 1'b0;
            tx_brk_reg     <= break_tx_trigger_reg;
            tx_cnt_reg     <= break_tx_trigger_reg ? 4'(`ASU_BRK_TX_BITS) - 4'h1 : tx_nbits;
            tx_shift_reg   <= {parity_bit(transmit_buffer,
                               operation_mode_reg[`ASU_BIT_PS_HI:`ASU_BIT_PS_LO],
                               operation_mode_reg[`ASU_BIT_CLEN]), transmit_buffer};
            tx_state_reg   <= break_tx_trigger_reg ? asu_pkg::ASU_START : asu_pkg::ASU_DATA;
          end else if (baud_tick) begin
            // Last stop bit has ended
            tx_busy_reg <= 1'b0;
          end
          asu_pkg::ASU_START: if (baud_tick) begin
            if (tx_cnt_reg == 4'h0) begin
              tx_cnt_reg     <= 4'h0;
              serial_tx_line <= 1'b1;
              tx_state_reg   <= asu_pkg::ASU_STOP;
            end else begin
              tx_cnt_reg <= tx_cnt_reg - 4'h1;
            end
          end
          asu_pkg::ASU_DATA: if (baud_tick) begin
            serial_tx_line <= tx_shift_reg[0];
            tx_shift_reg   <= {1'b1, tx_shift_reg[8:1]};
            tx_cnt_reg     <= tx_cnt_reg - 4'h1;
            if (tx_cnt_reg == 4'h1) begin
              tx_state_reg <= (operation_mode_reg[`ASU_BIT_PS_HI:`ASU_BIT_PS_LO] != 2'h0) ?
                              asu_pkg::ASU_PAR : asu_pkg::ASU_STOP;
              if (!operation_mode_reg[`ASU_BIT_CLEN]) begin
                tx_shift_reg <= {2'h3, tx_shift_reg[7:1]};
              end
            end
          end
          asu_pkg::ASU_PAR: if (baud_tick) begin
            serial_tx_line <= tx_shift_reg[0];
            tx_state_reg   <= asu_pkg::ASU_STOP;
            tx_cnt_reg     <= 4'h0;
          end
          asu_pkg::ASU_STOP: if (baud_tick) begin
            serial_tx_line <= 1'b1;
            // Second and third stop bit only on transmit
            if (operation_mode_reg[`ASU_BIT_STOP2] && tx_cnt_reg == 4'h0 && !tx_brk_reg) begin
              tx_cnt_reg <= 4'h1;
            end else if (tx_cnt_reg == 4'h2 || !operation_mode_reg[`ASU_BIT_STOP2] ||
                         tx_brk_reg) begin
              tx_gap_reg   <= 2'(`ASU_GAP_CLKS);
              tx_state_reg <= asu_pkg::ASU_GAP;
            end else begin
              tx_cnt_reg <= 4'h2;
            end
          end
          asu_pkg::ASU_GAP: begin
            // Stop bit under way: two clocks before the next start may begin
            if (tx_gap_reg == 2'(`ASU_GAP_CLKS)) begin
              tx_done_pulse <= 1'b1;
            end
            if (tx_gap_reg == 2'h1) begin
              tx_state_reg <= asu_pkg::ASU_IDLE;
            end
            tx_gap_reg <= tx_gap_reg - 2'h1;
          end
          default: tx_state_reg <= asu_pkg::ASU_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  asu_pkg::asu_state_e rx_state_reg;
  logic [7:0]  rx_shift_reg;
  logic [4:0]  rx_cnt_reg;
  logic        rx_par_reg;
  logic        rx_skip_reg;
  logic        rx_full_reg;
  logic        brk_rx_go;

  assign brk_rx_go = apb_wr && paddr == `ASU_OFF_LINCTL && pwdata[`ASU_BIT_BRK_RX];
  assign brk_rx_ok = rx_state_reg == asu_pkg::ASU_START && rx_tick && break_rx_trigger_reg &&
                     !rx_s2_reg && rx_cnt_reg == 5'(`ASU_BRK_RX_BITS) - 5'h1;
  assign rx_tick   = (rx_tmr_reg == 24'h000000);

  // Bit timer restarts on each start edge so samples fall mid-bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_tmr_reg <= 24'h000000;
    end else if (rx_state_reg == asu_pkg::ASU_IDLE) begin
      rx_tmr_reg <= bit_clks(clock_select_reg, baud_control_reg) >> 1;
    end else if (rx_tick) begin
      rx_tmr_reg <= bit_clks(clock_select_reg, baud_control_reg) - 24'h000001;
    end else begin
      rx_tmr_reg <= rx_tmr_reg - 24'h000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_rx_trigger_reg <= 1'b0;
    end else if (!receive_enable) begin
      break_rx_trigger_reg <= 1'b0;
    end else if (brk_rx_go) begin
      break_rx_trigger_reg <= 1'b1;
    end else if (brk_rx_ok) begin
      break_rx_trigger_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg      <= asu_pkg::ASU_IDLE;
      rx_shift_reg      <= 8'h00;
      rx_cnt_reg        <= 5'h00;
      rx_par_reg        <= 1'b0;
      rx_skip_reg       <= 1'b0;
      rx_full_reg       <= 1'b0;
      receive_buffer    <= 8'h00;
      rx_err_reg        <= '0;
      break_rx_flag_reg <= 1'b0;
      rx_done_pulse     <= 1'b0;
    end else begin
      rx_done_pulse <= 1'b0;
      if (apb_rd && paddr == `ASU_OFF_RXBUF) begin
        rx_full_reg <= 1'b0;
      end
      if (apb_rd && paddr == `ASU_OFF_RXERR) begin
        rx_err_reg <= '0;
      end
      if (!receive_enable) begin
        rx_state_reg <= asu_pkg::ASU_IDLE;
      end else begin
        case (rx_state_reg)
          asu_pkg::ASU_IDLE: if (!rx_s2_reg) begin
            rx_state_reg <= asu_pkg::ASU_START;
            rx_cnt_reg   <= 5'h00;
          end
          asu_pkg::ASU_START: if (rx_tick) begin
            if (break_rx_trigger_reg) begin
              if (rx_s2_reg) begin
                // Break too short: flag stays held
                rx_state_reg <= asu_pkg::ASU_IDLE;
              end else if (rx_cnt_reg == 5'(`ASU_BRK_RX_BITS) - 5'h1) begin
                break_rx_flag_reg <= 1'b1;
                rx_done_pulse     <= 1'b1;
                rx_state_reg      <= asu_pkg::ASU_GAP;
              end else begin
                rx_cnt_reg <= rx_cnt_reg + 5'h01;
              end
            end else begin
              rx_state_reg <= asu_pkg::ASU_DATA;
              rx_cnt_reg   <= {1'b0, tx_nbits};
              rx_par_reg   <= 1'b0;
            end
          end
          asu_pkg::ASU_DATA: if (rx_tick) begin
            rx_shift_reg <= operation_mode_reg[`ASU_BIT_CLEN] ?
                            {rx_s2_reg, rx_shift_reg[7:1]} :
                            {1'b0, rx_s2_reg, rx_shift_reg[6:1]};
            rx_cnt_reg   <= rx_cnt_reg - 5'h01;
            if (rx_cnt_reg == 5'h01) begin
              rx_state_reg <= (operation_mode_reg[`ASU_BIT_PS_HI:`ASU_BIT_PS_LO] != 2'h0) ?
                              asu_pkg::ASU_PAR : asu_pkg::ASU_STOP;
            end
          end
          asu_pkg::ASU_PAR: if (rx_tick) begin
            rx_par_reg   <= rx_s2_reg;
            rx_state_reg <= asu_pkg::ASU_STOP;
          end
          asu_pkg::ASU_STOP: if (rx_tick) begin
            // One stop bit, only the first position examined
            rx_state_reg  <= asu_pkg::ASU_GAP;
            rx_done_pulse <= 1'b1;
            rx_err_reg.framing_error <= rx_err_reg.framing_error | !rx_s2_reg;
            if (operation_mode_reg[`ASU_BIT_PS_HI:`ASU_BIT_PS_LO] != 2'h1 &&
                operation_mode_reg[`ASU_BIT_PS_HI:`ASU_BIT_PS_LO] != 2'h0) begin
              rx_err_reg.parity_error_flag <= rx_err_reg.parity_error_flag |
                (rx_par_reg != parity_bit(rx_shift_reg,
                 operation_mode_reg[`ASU_BIT_PS_HI:`ASU_BIT_PS_LO],
                 operation_mode_reg[`ASU_BIT_CLEN]));
            end
            if (rx_full_reg || rx_skip_reg) begin
              rx_err_reg.overrun_error <= rx_err_reg.overrun_error | rx_full_reg;
              rx_skip_reg <= rx_full_reg && !rx_skip_reg;
            end else begin
              receive_buffer <= rx_shift_reg;
              rx_full_reg    <= 1'b1;
            end
          end
          asu_pkg::ASU_GAP: if (rx_s2_reg) begin
            rx_state_reg <= asu_pkg::ASU_IDLE;
          end
          default: rx_state_reg <= asu_pkg::ASU_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_busy_clear_gap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tx_done_pulse) |-> tx_busy_reg) else $error("busy low before stop end");
  a_ovr_keep_buf: assert property (@(posedge pclk) disable iff (!presetn)
    (receive_enable && rx_state_reg == asu_pkg::ASU_STOP && rx_tick && rx_full_reg) |=>
    receive_buffer == $past(receive_buffer)) else $error("overrun overwrote buffer");
  a_brk_rx_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (paddr == `ASU_OFF_LINCTL) |-> !prdata[`ASU_BIT_BRK_RX]) else $error("break rx trigger read");
  a_rx_start_low: assert property (@(posedge pclk) disable iff (!presetn)
    (receive_enable && rx_state_reg == asu_pkg::ASU_IDLE && !rx_s2_reg) |=>
    rx_state_reg == asu_pkg::ASU_START) else $error("start not taken");
  a_err_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && paddr == `ASU_OFF_RXERR && !wait_done_reg) |->
    !pready ##1 pready) else $error("no wait on error read");
  a_brk_trig_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_done_pulse && tx_brk_reg && !apb_wr) |=> !break_tx_trigger_reg)
    else $error("break trigger stuck");
endmodule
`default_nettype wire

/* bench/asu_remote_node.sv */
// Remote serial node: drives the receive line and captures the transmit line.
// Assumes a fixed bit time of BIT_CLKS pclk cycles, line idles high.
`default_nettype none
module asu_remote_node #(
  parameter int BIT_CLKS = 8
) (
  // Clock
  input  wire logic pclk,
  // Serial lines
  input  wire logic serial_tx_line,
  output logic      serial_rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got;
  int         n_got = 0;
  int         low_len = 0;
  initial serial_rx_line = 1'h1;
  task automatic hold(input logic v, input int bits);
    serial_rx_line <= v;
    repeat (bits * BIT_CLKS) @(posedge pclk);
  endtask
  // Start, 8 data bits LSB first, optional parity, one stop bit
  task automatic send(input logic [7:0] d, input int par, input logic stop);
    hold(1'h0, 1);
    for (int i = 0; i < 8; i++) hold(d[i], 1);
    if (par >= 0) hold(par[0], 1);
    hold(stop, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Capture one character, sampled mid-bit
  always begin
    @(negedge serial_tx_line);
    repeat (BIT_CLKS / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge pclk);
      got[i] = serial_tx_line;
    end
    n_got++;
    wait (serial_tx_line === 1'h1);
  end
  // Length of the last low run, for break fields
  always begin
    @(negedge serial_tx_line);
    low_len = 0;
    while (serial_tx_line === 1'h0) begin
      @(posedge pclk);
      low_len++;
    end
  end
endmodule
`default_nettype wire

/* bench/test_async_serial_lin_uart.sv */
// Directed testbench of the serial unit over APB with a remote node.
// Assumes asu_top and asu_remote_node are compiled before it.
`default_nettype none
`include "asu_defines.svh"
module test_async_serial_lin_uart;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int B = 8;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_rx_line;
  logic        serial_tx_line;
  logic        tx_done_pulse;
  logic        rx_done_pulse;
  logic [31:0] rdat;
  logic [31:0] waits;
  int          n_errors = 0;
  int          n_compared = 0;
  asu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line),
    .tx_done_pulse(tx_done_pulse), .rx_done_pulse(rx_done_pulse));
  asu_remote_node #(.BIT_CLKS(B)) u_node (.pclk(pclk), .serial_tx_line(serial_tx_line),
    .serial_rx_line(serial_rx_line));
  initial forever #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    waits = 32'h0;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      waits++;
      @(posedge pclk);
    end
    rdat = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_done(input logic rx);
    for (int i = 0; i < 40 * B; i++) begin
      @(posedge pclk);
      if ((rx ? rx_done_pulse : tx_done_pulse) === 1'h1) return;
    end
    chk(32'h0, 32'h1);
  endtask
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    xfer(1'h0, `ASU_OFF_MODE, 32'h0);
    chk(rdat, 32'h01);
    xfer(1'h0, `ASU_OFF_BAUD, 32'h0);
    chk(rdat, 32'hFF);
    xfer(1'h1, 12'h020, 32'hFF);
    xfer(1'h0, 12'h020, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_tx();
    xfer(1'h1, `ASU_OFF_BAUD, 32'h04);
    xfer(1'h1, `ASU_OFF_CLKSEL, 32'h0);
    xfer(1'h1, `ASU_OFF_MODE, 32'h84);
    xfer(1'h1, `ASU_OFF_MODE, 32'hE4);
    xfer(1'h1, `ASU_OFF_TXBUF, 32'hA5);
    repeat (2 * B) @(posedge pclk);
    xfer(1'h0, `ASU_OFF_TXSTAT, 32'h0);
    chk(rdat, 32'h1);
    wait_done(1'h0);
    chk({24'h0, u_node.got}, 32'hA5);
    repeat (B) @(posedge pclk);
    xfer(1'h0, `ASU_OFF_TXSTAT, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'h1, `ASU_OFF_TXBUF, 32'h5A);
    repeat (2 * B) @(posedge pclk);
    xfer(1'h0, `ASU_OFF_TXSTAT, 32'h0);
    chk(rdat, 32'h1);
    xfer(1'h1, `ASU_OFF_TXBUF, 32'hC3);
    xfer(1'h0, `ASU_OFF_TXSTAT, 32'h0);
    chk(rdat, 32'h3);
    wait_done(1'h0);
    chk({24'h0, u_node.got}, 32'h5A);
    wait_done(1'h0);
    chk({24'h0, u_node.got}, 32'hC3);
    $display("transmit test done");
  endtask
  task automatic t_rx();
    xfer(1'h1, `ASU_OFF_MODE, 32'h84);
    xfer(1'h1, `ASU_OFF_MODE, 32'hE6);
    fork
      begin
        u_node.send(8'h3C, -1, 1'h1);
        u_node.send(8'h96, -1, 1'h1);
      end
      begin
        wait_done(1'h1);
        xfer(1'h0, `ASU_OFF_RXBUF, 32'h0);
        chk(rdat, 32'h3C);
        wait_done(1'h1);
        xfer(1'h0, `ASU_OFF_RXBUF, 32'h0);
        chk(rdat, 32'h96);
      end
    join
    u_node.send(8'h55, -1, 1'h0);
    u_node.hold(1'h1, 2);
    xfer(1'h0, `ASU_OFF_RXERR, 32'h0);
    chk(rdat, 32'h2);
    chk(waits, 32'h1);
    xfer(1'h0, `ASU_OFF_RXERR, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'h0, `ASU_OFF_RXBUF, 32'h0);
    $display("receive test done");
  endtask
  task automatic t_parity();
    for (int m = 1; m < 4; m++) begin
      xfer(1'h1, `ASU_OFF_MODE, 32'h84);
      xfer(1'h1, `ASU_OFF_MODE, 32'hE4 | (32'(m) << 3));
      u_node.send(8'h01, 0, 1'h1);
      xfer(1'h0, `ASU_OFF_RXERR, 32'h0);
      chk(rdat, (m == 2) ? 32'h4 : 32'h0);
      xfer(1'h0, `ASU_OFF_RXBUF, 32'h0);
    end
    xfer(1'h1, `ASU_OFF_MODE, 32'h84);
    xfer(1'h1, `ASU_OFF_MODE, 32'hE4);
    $display("parity test done");
  endtask
  task automatic t_overrun();
    u_node.send(8'h11, -1, 1'h1);
    u_node.send(8'h22, -1, 1'h1);
    xfer(1'h0, `ASU_OFF_RXBUF, 32'h0);
    chk(rdat, 32'h11);
    u_node.send(8'h33, -1, 1'h1);
    xfer(1'h0, `ASU_OFF_RXBUF, 32'h0);
    chk(rdat, 32'h11);
    xfer(1'h0, `ASU_OFF_RXERR, 32'h0);
    chk(rdat, 32'h1);
    u_node.send(8'h44, -1, 1'h1);
    xfer(1'h0, `ASU_OFF_RXBUF, 32'h0);
    chk(rdat, 32'h44);
    $display("overrun test done");
  endtask
  task automatic t_low_start();
    xfer(1'h1, `ASU_OFF_MODE, 32'h84);
    u_node.hold(1'h0, 1);
    xfer(1'h1, `ASU_OFF_MODE, 32'hE4);
    fork
      begin
        u_node.hold(1'h0, 9);
        u_node.hold(1'h1, 2);
      end
      wait_done(1'h1);
    join
    xfer(1'h0, `ASU_OFF_RXBUF, 32'h0);
    chk(rdat, 32'h0);
    $display("low start test done");
  endtask
  task automatic t_break();
    xfer(1'h1, `ASU_OFF_LINCTL, 32'h40);
    wait_done(1'h0);
    repeat (B) @(posedge pclk);
    chk(32'((u_node.low_len + B / 2) / B), 32'd13);
    xfer(1'h0, `ASU_OFF_LINCTL, 32'h0);
    chk(rdat & 32'h40, 32'h0);
    xfer(1'h1, `ASU_OFF_LINCTL, 32'h20);
    u_node.hold(1'h0, 13);
    u_node.hold(1'h1, 2);
    xfer(1'h0, `ASU_OFF_LINCTL, 32'h0);
    chk(rdat & 32'hE0, 32'h80);
    xfer(1'h1, `ASU_OFF_LINCTL, 32'hA0);
    u_node.hold(1'h0, 5);
    u_node.hold(1'h1, 2);
    xfer(1'h0, `ASU_OFF_LINCTL, 32'h0);
    chk(rdat & 32'h80, 32'h80);
    $display("break test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_tx();
    t_rx();
    t_parity();
    t_overrun();
    t_low_start();
    t_break();
    stop_test();
  end
endmodule
`default_nettype wire
